// ==== msi_pkg.sv ====
// Overview of operation
// - ten 16-bit input words: two status, three position pairs, current, jerk.
// - decimal format puts last three digits low, higher digits in upper word.
// - binary format gives signed 32-bit positions, word order set by endian.
// - decimal span is -32,768,000 to 32,767,999; overflow leaves words undefined.
// - status zero bit 15 reads one in configuration mode, zero otherwise.
// - status zero bit 14 is one without internal fault, zero with one.
// - bit 13 in command mode flags a missing or invalid configuration.
// - bit 13 in configuration mode shows stall detection enabled; host checks bit 15.
// - bit 12 sets on invalid command, clears only by reset errors.
// - bit 11 sets on stop, limit, jog into limit, homing limit events.
// - bit 10 sets on config write, no home, link restore, stops, limit, stall.
// - absolute moves refused while position invalid; other moves ignore it.
// - bit 8 ready for assembled programming, bit 9 ready for next segment.
// - bit 7 sets on good move end; clears on move, preset, reset errors.
// - bit 7 also sets with jog or registration range errors, never homing.
// - bit 6 only while decelerating, bit 5 only while accelerating.
// - bit 4 is one after a successful homing, zero otherwise.
// - bit 3 is one whenever the motor is not moving.
// - bit 2 hold reached, bit 1 counter-clockwise, bit 0 clockwise.
// - status one bit 15 shows the driver enabled.
// - bit 14 stall; bit 13 acknowledges preset or reset until host clears.
// - bit 12 reports absolute encoder error on encoder units.
// - bit 11 toggles about every 500 ms, only in command mode.
// - reset errors clears move complete, not position invalid or config error.
package msi_pkg;
    localparam int          WORD_W      = 16;
    localparam int          NUM_WORDS   = 10;
    localparam logic [3:0]  IDX_SW0     = 4'h0;
    localparam logic [3:0]  IDX_SW1     = 4'h1;
    localparam logic [3:0]  IDX_MOT_UP  = 4'h2;
    localparam logic [3:0]  IDX_MOT_LO  = 4'h3;
    localparam logic [3:0]  IDX_ENC_UP  = 4'h4;
    localparam logic [3:0]  IDX_ENC_LO  = 4'h5;
    localparam logic [3:0]  IDX_CAP_UP  = 4'h6;
    localparam logic [3:0]  IDX_CAP_LO  = 4'h7;
    localparam logic [3:0]  IDX_CURRENT = 4'h8;
    localparam logic [3:0]  IDX_JERK    = 4'h9;
    // status word zero fields
    localparam int B0_MODE      = 15;
    localparam int B0_OK        = 14;
    localparam int B0_CFG_ERR   = 13;
    localparam int B0_CMD_ERR   = 12;
    localparam int B0_IN_ERR    = 11;
    localparam int B0_POS_INV   = 10;
    localparam int B0_SEG_REQ   = 9;
    localparam int B0_ASSY      = 8;
    localparam int B0_MOVE_DONE = 7;
    localparam int B0_DECEL     = 6;
    localparam int B0_ACCEL     = 5;
    localparam int B0_HOME      = 4;
    localparam int B0_STOPPED   = 3;
    localparam int B0_HOLD      = 2;
    localparam int B0_CCW       = 1;
    localparam int B0_CW        = 0;
    // status word one fields
    localparam int B1_DRV_EN    = 15;
    localparam int B1_STALL     = 14;
    localparam int B1_ACK       = 13;
    localparam int B1_ABS_ERR   = 12;
    localparam int B1_BEAT      = 11;
    // decimal split
    localparam logic signed [31:0] DEC_DIV = 32'sd1000;
    // reset values
    localparam logic CFG_ERR_RST = 1'b1;
    localparam logic POS_INV_RST = 1'b1;
    // heartbeat timing
    localparam int CLK_HZ       = 50_000_000;
    localparam int BEAT_MS      = 500;
    localparam int BEAT_CYCLES  = CLK_HZ / 1000 * BEAT_MS;
endpackage : msi_pkg

// ==== msi_input_data.sv ====
`timescale 1ns/1ps
module msi_input_data
    import msi_pkg::*;
#(
    parameter int BEAT_COUNT = BEAT_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    // word read port
    input  wire logic [3:0]  rd_index,
    output logic [15:0]      rd_data,
    // mode and health
    input  wire logic        config_mode,
    input  wire logic        internal_fault,
    input  wire logic        stall_detect_en,
    input  wire logic        cfg_valid_wr,
    input  wire logic        cfg_invalid_wr,
    // error events
    input  wire logic        invalid_cmd,
    input  wire logic        reset_errors,
    input  wire logic        estop_evt,
    input  wire logic        limit_in_move,
    input  wire logic        jog_into_limit,
    input  wire logic        home_far_limit,
    input  wire logic        link_restored,
    input  wire logic        stop_evt,
    input  wire logic        limit_reached,
    input  wire logic        stall_evt,
    // position reference
    input  wire logic        pos_preset,
    input  wire logic        enc_preset,
    input  wire logic        homing_done_evt,
    // moves
    input  wire logic        move_cmd,
    input  wire logic        abs_move_req,
    input  wire logic        move_done_ok,
    input  wire logic        move_is_homing,
    input  wire logic        jogreg_range_err,
    input  wire logic        assy_ready,
    input  wire logic        segment_request,
    input  wire logic        accelerating,
    input  wire logic        decelerating,
    input  wire logic        motor_moving,
    input  wire logic        dir_ccw,
    input  wire logic        hold_reached,
    // driver and host handshake
    input  wire logic        drive_enabled,
    input  wire logic        host_cmd_clear,
    input  wire logic        abs_enc_fault,
    // data sources
    input  wire logic        binary_fmt,
    input  wire logic        binary_endian,
    input  wire logic [31:0] motor_pos,
    input  wire logic [31:0] encoder_pos,
    input  wire logic [31:0] captured_pos,
    input  wire logic [15:0] current_x10,
    input  wire logic [15:0] jerk_value,
    // move gate and mirrored status flags
    output logic             abs_move_ok,
    output logic             abs_move_refused,
    output logic             homing_done,
    output logic             turning_clockwise,
    output logic             turning_counterclockwise
);

    ////////////////////////////////////////////////////////////////
    // sticky status flags

    logic cfg_err_q;
    logic cmd_err_q;
    logic in_err_q;
    logic pos_inv_q;
    logic move_done_q;
    logic home_q;
    logic ack_q;
    logic beat_q;
    logic [31:0] beat_cnt_q;

    // configuration error, power-up set, valid config clears
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_err_q <= CFG_ERR_RST;
        end else if (cfg_invalid_wr) begin
            cfg_err_q <= 1'b1;
        end else if (cfg_valid_wr) begin
            cfg_err_q <= 1'b0;
        end
    end

    // command error, only reset errors clears, set wins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_err_q <= 1'b0;
        end else if (invalid_cmd | jogreg_range_err) begin
            cmd_err_q <= 1'b1;
        end else if (reset_errors) begin
            cmd_err_q <= 1'b0;
        end
    end

    // input error from stop and limit events
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            in_err_q <= 1'b0;
        end else if (estop_evt | limit_in_move | jog_into_limit | home_far_limit) begin
            in_err_q <= 1'b1;
        end else if (reset_errors) begin
            in_err_q <= 1'b0;
        end
    end

    // position invalid: set at power-up, cleared by preset or home
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pos_inv_q <= POS_INV_RST;
        end else if (cfg_valid_wr | cfg_invalid_wr | link_restored
                     | stop_evt | estop_evt | limit_reached | stall_evt) begin
            pos_inv_q <= 1'b1;
        end else if (pos_preset | homing_done_evt) begin
            pos_inv_q <= 1'b0;
        end
    end

    // absolute move gate
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            abs_move_ok      <= 1'b0;
            abs_move_refused <= 1'b0;
        end else begin
            abs_move_ok      <= abs_move_req & ~pos_inv_q;
            abs_move_refused <= abs_move_req & pos_inv_q;
        end
    end

    // move complete; homing end never sets it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            move_done_q <= 1'b0;
        end else if ((move_done_ok & ~move_is_homing) | jogreg_range_err) begin
            move_done_q <= 1'b1;
        end else if (move_cmd | pos_preset | reset_errors) begin
            move_done_q <= 1'b0;
        end
    end

    // homing_done until the next move, position preset or stop
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            home_q <= 1'b0;
        end else if (homing_done_evt) begin
            home_q <= 1'b1;
        end else if (move_cmd | pos_preset | stop_evt) begin
            home_q <= 1'b0;
        end
    end

    // command acknowledge until host drops the command bit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else if (pos_preset | enc_preset | reset_errors) begin
            ack_q <= 1'b1;
        end else if (host_cmd_clear) begin
            ack_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // heartbeat

    // toggles each period, frozen in configuration mode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            beat_cnt_q <= 32'h0000_0000;
            beat_q     <= 1'b0;
        end else if (config_mode) begin
            beat_cnt_q <= 32'h0000_0000;
        end else if (beat_cnt_q >= 32'(BEAT_COUNT - 1)) begin
            beat_cnt_q <= 32'h0000_0000;
            beat_q     <= ~beat_q;
        end else begin
            beat_cnt_q <= beat_cnt_q + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////
    // word assembly

    logic [15:0] sw0_d;
    logic [15:0] sw1_d;
    logic [15:0] pos_w_d [6];

    // status word zero and one from flags and live levels
    always_comb begin
        sw0_d                = 16'h0000;
        sw0_d[B0_MODE]       = config_mode;
        sw0_d[B0_OK]         = ~internal_fault;
        sw0_d[B0_CFG_ERR]    = config_mode ? stall_detect_en : cfg_err_q;
        sw0_d[B0_CMD_ERR]    = cmd_err_q;
        sw0_d[B0_IN_ERR]     = in_err_q;
        sw0_d[B0_POS_INV]    = pos_inv_q;
        sw0_d[B0_SEG_REQ]    = segment_request;
        sw0_d[B0_ASSY]       = assy_ready;
        sw0_d[B0_MOVE_DONE]  = move_done_q;
        sw0_d[B0_DECEL]      = motor_moving & decelerating;
        sw0_d[B0_ACCEL]      = motor_moving & accelerating & ~decelerating;
        sw0_d[B0_HOME]       = home_q;
        sw0_d[B0_STOPPED]    = ~motor_moving;
        sw0_d[B0_HOLD]       = hold_reached;
        sw0_d[B0_CCW]        = motor_moving & dir_ccw;
        sw0_d[B0_CW]         = motor_moving & ~dir_ccw;
        sw1_d                = 16'h0000;
        sw1_d[B1_DRV_EN]     = drive_enabled;
        sw1_d[B1_STALL]      = stall_evt;
        sw1_d[B1_ACK]        = ack_q;
        sw1_d[B1_ABS_ERR]    = abs_enc_fault;
        sw1_d[B1_BEAT]       = beat_q;
    end

    // one position into its two words
    function automatic logic [31:0] fmt_pos(input logic [31:0] p, input logic bin, input logic endn);
        logic signed [31:0] q;
        logic signed [31:0] r;
        q = $signed(p) / DEC_DIV;
        r = $signed(p) - q * DEC_DIV;
        if (bin) begin
            fmt_pos = endn ? {p[15:0], p[31:16]} : p;
        end else begin
            fmt_pos = {q[15:0], r[15:0]};
        end
    endfunction

    logic [31:0] src_pos [3];
    assign src_pos[0] = motor_pos;
    assign src_pos[1] = encoder_pos;
    assign src_pos[2] = captured_pos;

    // upper then lower word for each position
    for (genvar g = 0; g < 3; g++) begin : g_pos
        logic [31:0] pair;
        assign pair          = fmt_pos(src_pos[g], binary_fmt, binary_endian);
        assign pos_w_d[2*g]  = pair[31:16];
        assign pos_w_d[2*g+1] = pair[15:0];
    end

    ////////////////////////////////////////////////////////////////
    // coherent image

    logic [15:0] image_q [NUM_WORDS];

    // all ten words captured on the same edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                image_q[i] <= 16'h0000;
            end
        end else begin
            image_q[IDX_SW0]     <= sw0_d;
            image_q[IDX_SW1]     <= sw1_d;
            image_q[IDX_MOT_UP]  <= pos_w_d[0];
            image_q[IDX_MOT_LO]  <= pos_w_d[1];
            image_q[IDX_ENC_UP]  <= pos_w_d[2];
            image_q[IDX_ENC_LO]  <= pos_w_d[3];
            image_q[IDX_CAP_UP]  <= pos_w_d[4];
            image_q[IDX_CAP_LO]  <= pos_w_d[5];
            image_q[IDX_CURRENT] <= current_x10;
            image_q[IDX_JERK]    <= jerk_value;
        end
    end

    // registered read, unmapped index reads zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 16'h0000;
        end else if (rd_index < 4'(NUM_WORDS)) begin
            rd_data <= image_q[rd_index];
        end else begin
            rd_data <= 16'h0000;
        end
    end

    // mirrored flags from sw0_d, registered on the same edge as the image
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            homing_done              <= 1'b0;
            turning_clockwise        <= 1'b0;
            turning_counterclockwise <= 1'b0;
        end else begin
            homing_done              <= sw0_d[B0_HOME];
            turning_clockwise        <= sw0_d[B0_CW];
            turning_counterclockwise <= sw0_d[B0_CCW];
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_cfg_mode_bit;
        ##1 image_q[IDX_SW0][B0_MODE] == $past(config_mode);
    endproperty
    a_cfg_mode_bit: assert property (p_cfg_mode_bit) else $error("mode bit wrong");

    property p_cmd_err_hold;
        cmd_err_q && !reset_errors |=> cmd_err_q;
    endproperty
    a_cmd_err_hold: assert property (p_cmd_err_hold) else $error("command error dropped");

    property p_in_err_set;
        estop_evt |=> in_err_q ##1 image_q[IDX_SW0][B0_IN_ERR];
    endproperty
    a_in_err_set: assert property (p_in_err_set) else $error("input error not set");

    property p_abs_refuse;
        abs_move_req && pos_inv_q |=> abs_move_refused && !abs_move_ok;
    endproperty
    a_abs_refuse: assert property (p_abs_refuse) else $error("absolute move not refused");

    property p_done_clear;
        move_cmd && !move_done_ok && !jogreg_range_err |=> !move_done_q;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("move complete not cleared");

    property p_reset_keeps_posinv;
        reset_errors && pos_inv_q |=> pos_inv_q;
    endproperty
    a_reset_keeps_posinv: assert property (p_reset_keeps_posinv) else $error("reset cleared position invalid");

    property p_stopped;
        !motor_moving |-> ##1 image_q[IDX_SW0][B0_STOPPED];
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped bit missing");

    property p_ack_set;
        reset_errors |=> ack_q;
    endproperty
    a_ack_set: assert property (p_ack_set) else $error("acknowledge not set");

    property p_beat_frozen;
        config_mode && $past(config_mode) |-> $stable(beat_q);
    endproperty
    a_beat_frozen: assert property (p_beat_frozen) else $error("heartbeat toggled in config mode");

    property p_bin_coherent;
        binary_fmt && !binary_endian |=> {image_q[IDX_MOT_UP], image_q[IDX_MOT_LO]} == $past(motor_pos);
    endproperty
    a_bin_coherent: assert property (p_bin_coherent) else $error("binary position words wrong");

    // a clean move end always raises move complete
    property p_done_set;
        move_done_ok && !move_is_homing |=> move_done_q;
    endproperty
    a_done_set: assert property (p_done_set) else $error("move complete not set");

    // the end of homing alone never raises move complete
    property p_home_no_done;
        move_done_ok && move_is_homing && !jogreg_range_err && !move_done_q |=> !move_done_q;
    endproperty
    a_home_no_done: assert property (p_home_no_done) else $error("homing set move complete");

    // a detected stall invalidates the position
    property p_stall_posinv;
        stall_evt |=> pos_inv_q;
    endproperty
    a_stall_posinv: assert property (p_stall_posinv) else $error("stall left position valid");

    // accelerating and decelerating never show together
    property p_ramp_excl;
        image_q[IDX_SW0][B0_ACCEL] |-> !image_q[IDX_SW0][B0_DECEL];
    endproperty
    a_ramp_excl: assert property (p_ramp_excl) else $error("accel and decel both set");

    c_homing: cover property (homing_done_evt ##1 home_q ##1 move_cmd);
    c_jog_err: cover property (jogreg_range_err ##1 (cmd_err_q && move_done_q));
    c_beat: cover property ($rose(beat_q));
    c_abs_refused: cover property (abs_move_refused);

endmodule // msi_input_data

// ==== msi_host_model.sv ====
`timescale 1ns/1ps
module msi_host_model
    import msi_pkg::*;
(
    input  wire logic        clock,
    output logic [3:0]       rd_index,
    input  wire logic [15:0] rd_data
);
    initial rd_index = 4'h0;

    // one word read: index moves on the falling edge, held across two rising edges
    task automatic read_word(input logic [3:0] idx, output logic [15:0] w);
        @(negedge clock);
        rd_index = idx;
        repeat (2) @(posedge clock);
        @(negedge clock);
        w = rd_data;
    endtask

    // bit 13 counts as a config error only outside configuration mode
    function automatic logic cfg_error(input logic [15:0] sw0);
        return sw0[B0_CFG_ERR] & ~sw0[B0_MODE];
    endfunction
endmodule // msi_host_model

// ==== test_motion_status_input_data.sv ====
`timescale 1ns/1ps
module test_motion_status_input_data
    import msi_pkg::*;
;
    logic               clock;
    logic               rst_n;
    logic [19:0]        ev;
    logic [14:0]        lv;
    logic [31:0]        mpos;
    logic [31:0]        epos;
    logic [31:0]        cpos;
    logic [15:0]        cur;
    logic [15:0]        jerk;
    logic [15:0]        w;
    logic [3:0]         rd_index;
    logic [15:0]        rd_data;
    logic               ok_p;
    logic               ref_p;
    logic               home_o;
    logic               cw_o;
    logic               ccw_o;
    int                 errors;
    int                 total_checks;
    int                 pi [5] = '{0, 4, 5, 6, 7};
    logic signed [31:0] pv [4] = '{32'h01F3_FFFF, 32'hFE0C_0000, 32'hFFFF_FFFF, 32'h0012_D687};

    ////////////////////////////////////////////////////////////////////////////////
    // event pulses packed in ev, levels packed in lv
    msi_input_data #(.BEAT_COUNT(8)) u_msi_input_data (
        .clock(clock), .rst_n(rst_n), .rd_index(rd_index), .rd_data(rd_data),
        .config_mode(lv[0]), .internal_fault(lv[1]), .stall_detect_en(lv[2]),
        .cfg_valid_wr(ev[10]), .cfg_invalid_wr(ev[11]), .invalid_cmd(ev[8]), .reset_errors(ev[9]),
        .estop_evt(ev[0]), .limit_in_move(ev[1]), .jog_into_limit(ev[2]), .home_far_limit(ev[3]),
        .link_restored(ev[4]), .stop_evt(ev[5]), .limit_reached(ev[6]), .stall_evt(ev[7]),
        .pos_preset(ev[12]), .enc_preset(ev[13]), .homing_done_evt(ev[14]), .move_cmd(ev[15]),
        .abs_move_req(ev[16]), .move_done_ok(ev[17]), .move_is_homing(lv[3]),
        .jogreg_range_err(ev[18]), .assy_ready(lv[4]), .segment_request(lv[5]),
        .accelerating(lv[6]), .decelerating(lv[7]), .motor_moving(lv[8]), .dir_ccw(lv[9]),
        .hold_reached(lv[10]), .drive_enabled(lv[11]), .host_cmd_clear(ev[19]),
        .abs_enc_fault(lv[12]), .binary_fmt(lv[13]), .binary_endian(lv[14]),
        .motor_pos(mpos), .encoder_pos(epos), .captured_pos(cpos), .current_x10(cur),
        .jerk_value(jerk), .abs_move_ok(ok_p), .abs_move_refused(ref_p), .homing_done(home_o),
        .turning_clockwise(cw_o), .turning_counterclockwise(ccw_o)
    );

    msi_host_model u_msi_host_model (.clock(clock), .rd_index(rd_index), .rd_data(rd_data));

    ////////////////////////////////////////////////////////////////////////////////
    // word compare
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // read a word and compare the masked bits
    task automatic mchk(input logic [3:0] i, input logic [15:0] m, input logic [15:0] e);
        u_msi_host_model.read_word(i, w);
        chk(w & m, e);
    endtask

    // one-cycle event pulse, then let the image settle
    task automatic pulse(input int k);
        @(negedge clock);
        ev[k] = 1'b1;
        @(negedge clock);
        ev = '0;
        repeat (3) @(negedge clock);
    endtask

    // level change, then let the image settle
    task automatic lvl(input int k, input logic v);
        @(negedge clock);
        lv[k] = v;
        repeat (3) @(negedge clock);
    endtask

    // absolute move request, answer checked one cycle later
    task automatic absreq(input logic e_ok);
        @(negedge clock);
        ev[16] = 1'b1;
        @(negedge clock);
        ev = '0;
        chk({14'h0, ok_p, ref_p}, {14'h0, e_ok, ~e_ok});
    endtask

    // count heartbeat changes over a stretch of reads
    task automatic beats(input logic e);
        int   n;
        logic p;
        n = 0;
        u_msi_host_model.read_word(4'h1, w);
        p = w[B1_BEAT];
        repeat (12) begin
            u_msi_host_model.read_word(4'h1, w);
            if (w[B1_BEAT] !== p) n++;
            p = w[B1_BEAT];
        end
        chk({15'h0, n > 1}, {15'h0, e});
    endtask

    // expected split decimal words, upper then lower
    function automatic logic [31:0] dec(input logic signed [31:0] p);
        logic signed [31:0] u;
        logic signed [31:0] r;
        u = p / DEC_DIV;
        r = p - u * DEC_DIV;
        return {u[15:0], r[15:0]};
    endfunction

    // positions in format m: 0 decimal, 1 binary, 2 binary swapped
    task automatic pchk(input logic signed [31:0] v, input int m);
        logic signed [31:0] s [3];
        logic [31:0]        e;
        s = '{v, v >>> 1, v >>> 2};
        @(negedge clock);
        mpos = s[0];
        epos = s[1];
        cpos = s[2];
        lv[14:13] = (m == 0) ? 2'b00 : ((m == 1) ? 2'b01 : 2'b11);
        repeat (3) @(negedge clock);
        for (int i = 0; i < 3; i++) begin
            e = (m == 0) ? dec(s[i]) : ((m == 1) ? s[i] : {s[i][15:0], s[i][31:16]});
            mchk(4'(2 + 2 * i), 16'hFFFF, e[31:16]);
            mchk(4'(3 + 2 * i), 16'hFFFF, e[15:0]);
        end
    endtask

    // verdict and end of run
    task automatic summarize;
        if (errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial begin
        #1_000_000;
        errors++;
        summarize();
    end

    // main sequence
    initial begin
        errors = 0;
        total_checks = 0;
        rst_n = 1'b0;
        ev = '0;
        lv = '0;
        {mpos, epos, cpos} = '0;
        cur = 16'h0123;
        jerk = 16'h1388;
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        mchk(4'h0, 16'hFFFF, 16'h6408);
        for (int i = 10; i < 16; i++) mchk(4'(i), 16'hFFFF, 16'h0000);
        mchk(4'h8, 16'hFFFF, 16'h0123);
        mchk(4'h9, 16'hFFFF, 16'h1388);
        absreq(1'b0);
        pulse(12);
        mchk(4'h0, 16'h0400, 16'h0000);
        mchk(4'h1, 16'h2000, 16'h2000);
        pulse(19);
        mchk(4'h1, 16'h2000, 16'h0000);
        absreq(1'b1);
        pulse(10);
        mchk(4'h0, 16'h2400, 16'h0400);
        pulse(11);
        mchk(4'h0, 16'h2000, 16'h2000);
        lvl(0, 1'b1);
        lvl(2, 1'b1);
        u_msi_host_model.read_word(4'h0, w);
        chk({15'h0, u_msi_host_model.cfg_error(w)}, 16'h0000);
        mchk(4'h0, 16'hA000, 16'hA000);
        beats(1'b0);
        lvl(2, 1'b0);
        mchk(4'h0, 16'h2000, 16'h0000);
        lvl(0, 1'b0);
        mchk(4'h0, 16'hA000, 16'h2000);
        beats(1'b1);
        pulse(10);
        for (int k = 0; k < 4; k++) begin
            pulse(k);
            mchk(4'h0, 16'h0800, 16'h0800);
            pulse(9);
            mchk(4'h0, 16'h0800, 16'h0000);
        end
        foreach (pi[j]) begin
            pulse(12);
            pulse(pi[j]);
            mchk(4'h0, 16'h0400, 16'h0400);
        end
        @(negedge clock);
        ev[7] = 1'b1;
        mchk(4'h1, 16'h4000, 16'h4000);
        ev = '0;
        pulse(11);
        pulse(5);
        pulse(8);
        pulse(17);
        mchk(4'h0, 16'hFFFF, 16'h7C88);
        pulse(9);
        mchk(4'h0, 16'hFFFF, 16'h6408);
        mchk(4'h1, 16'h2000, 16'h2000);
        pulse(19);
        pulse(10);
        pulse(17);
        mchk(4'h0, 16'h0080, 16'h0080);
        pulse(15);
        mchk(4'h0, 16'h0080, 16'h0000);
        pulse(17);
        pulse(12);
        mchk(4'h0, 16'h0080, 16'h0000);
        lvl(3, 1'b1);
        pulse(17);
        mchk(4'h0, 16'h0080, 16'h0000);
        lvl(3, 1'b0);
        pulse(18);
        mchk(4'h0, 16'h1080, 16'h1080);
        pulse(9);
        pulse(14);
        mchk(4'h0, 16'h0010, 16'h0010);
        chk({15'h0, home_o}, 16'h0001);
        pulse(15);
        mchk(4'h0, 16'h0010, 16'h0000);
        lvl(8, 1'b1);
        lvl(6, 1'b1);
        mchk(4'h0, 16'h006B, 16'h0021);
        chk({14'h0, cw_o, ccw_o}, 16'h0002);
        lvl(7, 1'b1);
        lvl(9, 1'b1);
        mchk(4'h0, 16'h006B, 16'h0042);
        lvl(8, 1'b0);
        lvl(6, 1'b0);
        lvl(7, 1'b0);
        lvl(10, 1'b1);
        mchk(4'h0, 16'h006F, 16'h000C);
        lvl(4, 1'b1);
        lvl(5, 1'b1);
        mchk(4'h0, 16'h0300, 16'h0300);
        lvl(11, 1'b1);
        lvl(12, 1'b1);
        mchk(4'h1, 16'hD000, 16'h9000);
        lvl(1, 1'b1);
        mchk(4'h0, 16'h4000, 16'h0000);
        for (int m = 0; m < 3; m++) foreach (pv[j]) pchk(pv[j], m);
        summarize();
    end
endmodule // test_motion_status_input_data
